// ---- include/cath_defs.svh ----
// Constants of the card APDU transport handler
`ifndef CATH_DEFS_SVH
`define CATH_DEFS_SVH
`define CATH_HDR_INS 9'h001
`define CATH_T1_HDR_LAST 9'h003
`define CATH_HDR_P3 9'h004
`define CATH_PB_NULL 8'h60
`define CATH_SW1_GET 8'h61
`define CATH_SW1_WARN 8'h62
`define CATH_SW1_WARN2 8'h63
`define CATH_SW1_LEN 8'h6C
`define CATH_SW1_APP 4'h9
`define CATH_SW_OK 16'h9000
`define CATH_SW_ERR 16'h6F00
`define CATH_INS_GET_RSP 8'hC0
`define CATH_LEN_MAX 9'h100
`endif

// ---- include/cath_pkg.sv ----
// Types and status decoding shared by both ends
package cath_pkg;
`include "cath_defs.svh"
  typedef enum logic [1:0] {CASE_1, CASE_2, CASE_3, CASE_4} cath_case_t;

  // Warning or application status other than plain success
  function automatic logic cath_sw_warn(input logic [15:0] sw);
    return sw[15:8] == `CATH_SW1_WARN || sw[15:8] == `CATH_SW1_WARN2 ||
      (sw[15:12] == `CATH_SW1_APP && sw != `CATH_SW_OK);
  endfunction

  // Status that may carry response data on the block protocol
  function automatic logic cath_sw_data(input logic [15:0] sw);
    return cath_sw_warn(sw) || sw == `CATH_SW_OK || sw[15:8] == `CATH_SW1_GET;
  endfunction

  // Expected length: zero stands for the maximum
  function automatic logic [8:0] cath_le(input logic [7:0] p3);
    return (p3 == 8'h00) ? `CATH_LEN_MAX : {1'b0, p3};
  endfunction
endpackage

// ---- include/cath_link_if.sv ----
// Byte link joining the card end and the terminal end
`timescale 1ns/1ns
interface cath_link_if;
  logic t1_mode;
  logic [7:0] t2c_dat;
  logic t2c_vld;
  logic t2c_last;
  logic t2c_more;
  logic t2c_rdy;
  logic [7:0] c2t_dat;
  logic c2t_vld;
  logic c2t_last;
  logic c2t_more;
  logic c2t_rdy;

  modport card (
    input t1_mode, t2c_dat, t2c_vld, t2c_last, t2c_more, c2t_rdy,
    output t2c_rdy, c2t_dat, c2t_vld, c2t_last, c2t_more
  );
  modport term (
    output t1_mode, t2c_dat, t2c_vld, t2c_last, t2c_more, c2t_rdy,
    input t2c_rdy, c2t_dat, c2t_vld, c2t_last, c2t_more
  );
endinterface

// ---- src/cath_blk_seg.sv ----
// Splits an outgoing message into chained blocks of at most IFS bytes
`timescale 1ns/1ns
module cath_blk_seg #(
  parameter int IFS = 32
)
(
  input logic core_clk,
  input logic rst_n,
  input logic beat,
  input logic msg_last,
  output logic blk_last,
  output logic blk_more
);
  logic [7:0] cnt_r;

  // Bytes already placed in the current block
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || (beat && blk_last))
      cnt_r <= 8'h00;
    else if (beat)
      cnt_r <= cnt_r + 8'h01;
  end

  // A block closes when full or at message end; chaining stays on until the end
  assign blk_last = msg_last || (cnt_r == 8'(IFS - 1));
  assign blk_more = !msg_last;
endmodule

// ---- src/cath_card.sv ----
// Card end of the APDU transport: header parsing, procedure bytes, status, chaining
//
// Contract
// [R01] Case 1 header carries zero length byte
// [R02] Case 2: data then status, else status
// [R03] Terminal ends case 2 on status
// [R04] Case 3 data length is 1 to 255
// [R05] Terminal sends data on procedure byte only
// [R06] Case 3 status only after all data
// [R07] Case 4 header drops the expected length
// [R08] Case 4 data answered by get-response
// [R09] Get-response length not above offered length
// [R10] Case 4 warning status triggers get-response
// [R11] Case 4 get-response handled as case 2
// [R12] Length procedure bytes only cases 2, 4
// [R13] Length-correction resends header with new length
// [R14] Errors may replace procedure bytes with status
// [R15] Wrong case 2 length answered by correction
// [R16] Exact case 2 length sends data, status
// [R17] Short case 2 request: data then get-response
// [R18] Case 4 result: get-response or non-success
// [R19] Block protocol carries messages unchanged
// [R20] Block protocol data only with allowed status
// [R21] Long responses chain across blocks
// [R22] Long commands chain across blocks
// [R23] Any final status ends the exchange
`timescale 1ns/1ns
`include "cath_defs.svh"
module cath_card
  import cath_pkg::*;
#(
  parameter int IFSD = 32
)
(
  input logic core_clk,
  input logic rst_n,
  cath_link_if.card lnk,
  output logic [7:0] cmd_byte,
  output logic cmd_vld,
  output logic cmd_end,
  input logic rsp_vld,
  input cath_case_t rsp_case,
  input logic rsp_ok,
  input logic [15:0] rsp_sw,
  input logic [8:0] rsp_len,
  input logic [7:0] rsp_dat,
  output logic dat_adv
);
  typedef enum logic [3:0] {ST_RX_HDR, ST_WAIT_HDR, ST_ACK, ST_RX_DAT, ST_WAIT_DONE,
    ST_TX_DAT, ST_SW1, ST_SW2, ST_RX_T1, ST_WAIT_T1} cath_card_st_t;

  cath_card_st_t st_r;
  cath_card_st_t st_nxt;
  cath_case_t case_r;
  logic [8:0] cnt_r;
  logic [8:0] cnt_nxt;
  logic [8:0] le;
  logic [15:0] sw_r;
  logic [15:0] sw_nxt;
  logic [7:0] ins_r;
  logic [7:0] p3_r;
  logic [7:0] c2t_dat_r;
  logic c2t_vld_r;
  logic c2t_last_r;
  logic c2t_more_r;
  logic rdy_r;
  logic [7:0] cmd_byte_r;
  logic cmd_vld_r;
  logic cmd_end_r;
  logic dat_adv_r;
  logic tx_ld;
  logic [7:0] tx_byte;
  logic adv;
  logic fin;
  logic rx_take;
  logic tx_free;
  logic seg_last;
  logic seg_more;

  // Procedure bytes never leave as final status; success is barred after a refusal
  function automatic logic [15:0] card_sw(input logic [15:0] sw, input logic ok_allowed);
    if (sw[15:8] == `CATH_SW1_GET || sw[15:8] == `CATH_SW1_LEN ||
        (!ok_allowed && sw == `CATH_SW_OK))
      return `CATH_SW_ERR;
    return sw;
  endfunction

  assign rx_take = lnk.t2c_vld && rdy_r;
  assign tx_free = !c2t_vld_r || lnk.c2t_rdy;

  // Chaining of outgoing block protocol responses
  cath_blk_seg #(
    .IFS(IFSD)
  ) u_seg (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .beat(tx_ld && lnk.t1_mode),
    .msg_last(st_r == ST_SW2),
    .blk_last(seg_last),
    .blk_more(seg_more)
  );

  // Exchange sequencing
  always_comb
  begin
    le = cath_le(p3_r);
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sw_nxt = sw_r;
    tx_ld = 1'b0;
    tx_byte = 8'h00;
    adv = 1'b0;
    fin = 1'b0;
    unique case (st_r)
      ST_RX_HDR:
      begin
        if (lnk.t1_mode)
          st_nxt = ST_RX_T1;
        else if (rx_take)
        begin
          cnt_nxt = cnt_r + 9'h001;
          if (cnt_r == `CATH_HDR_P3)
          begin
            fin = 1'b1;
            st_nxt = ST_WAIT_HDR;
          end
        end
      end
      ST_WAIT_HDR:
      begin
        if (rsp_vld)
        begin
          st_nxt = ST_SW1;
          cnt_nxt = le;
          if (!rsp_ok || (rsp_case == CASE_2 && rsp_len == 9'h000))
            sw_nxt = card_sw(rsp_sw, 1'b0); // R02 R14
          else if (rsp_case == CASE_1)
            sw_nxt = card_sw(rsp_sw, 1'b1);
          else if (rsp_case != CASE_2)
            st_nxt = ST_ACK;
          else if ((p3_r == 8'h00 && rsp_len < `CATH_LEN_MAX) || le > rsp_len)
            sw_nxt = {`CATH_SW1_LEN, rsp_len[7:0]}; // R15 R12
          else
          begin
            st_nxt = ST_ACK; // R02 R11
            if (le == rsp_len)
              sw_nxt = card_sw(rsp_sw, 1'b1); // R16
            else
              sw_nxt = {`CATH_SW1_GET, 8'(rsp_len - le)}; // R17 R12
          end
        end
      end
      ST_ACK:
      begin
        if (tx_free)
        begin
          tx_ld = 1'b1;
          tx_byte = ins_r;
          st_nxt = (case_r == CASE_2) ? ST_TX_DAT : ST_RX_DAT;
        end
      end
      ST_RX_DAT:
      begin
        if (rx_take)
        begin
          cnt_nxt = cnt_r - 9'h001;
          if (cnt_r == 9'h001)
          begin
            fin = 1'b1;
            st_nxt = ST_WAIT_DONE; // R06
          end
        end
      end
      ST_WAIT_DONE:
      begin
        if (rsp_vld)
        begin
          st_nxt = ST_SW1; // R06
          if (!rsp_ok)
            sw_nxt = card_sw(rsp_sw, 1'b0); // R08 R14
          else if (case_r == CASE_4)
            sw_nxt = {`CATH_SW1_GET, rsp_len[7:0]}; // R08 R18 R12
          else
            sw_nxt = card_sw(rsp_sw, 1'b1);
        end
      end
      ST_TX_DAT:
      begin
        // No back-to-back loads, so the user has a cycle to step its data
        if (!c2t_vld_r)
        begin
          tx_ld = 1'b1;
          tx_byte = rsp_dat;
          adv = 1'b1;
          cnt_nxt = cnt_r - 9'h001;
          if (cnt_r == 9'h001)
            st_nxt = ST_SW1;
        end
      end
      ST_SW1:
      begin
        if (tx_free)
        begin
          tx_ld = 1'b1;
          tx_byte = sw_r[15:8];
          st_nxt = ST_SW2;
        end
      end
      ST_SW2:
      begin
        if (tx_free)
        begin
          tx_ld = 1'b1;
          tx_byte = sw_r[7:0];
          cnt_nxt = 9'h000;
          st_nxt = lnk.t1_mode ? ST_RX_T1 : ST_RX_HDR; // R23
        end
      end
      ST_RX_T1:
      begin
        if (rx_take && lnk.t2c_last && !lnk.t2c_more)
        begin
          fin = 1'b1; // R19 R22
          st_nxt = ST_WAIT_T1;
        end
      end
      ST_WAIT_T1:
      begin
        if (rsp_vld)
        begin
          st_nxt = ST_SW1;
          sw_nxt = (rsp_sw[15:8] == `CATH_SW1_LEN) ? `CATH_SW_ERR : rsp_sw; // R12
          if (rsp_ok && cath_sw_data(rsp_sw) && rsp_len != 9'h000)
          begin
            cnt_nxt = rsp_len; // R20
            st_nxt = ST_TX_DAT;
          end
        end
      end
    endcase
  end

  // State and command context
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st_r <= ST_RX_HDR;
      cnt_r <= 9'h000;
      sw_r <= 16'h0000;
      case_r <= CASE_1;
      ins_r <= 8'h00;
      p3_r <= 8'h00;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sw_r <= sw_nxt;
      if (st_r == ST_RX_HDR && rx_take && cnt_r == `CATH_HDR_INS)
        ins_r <= lnk.t2c_dat;
      if (st_r == ST_RX_HDR && rx_take && cnt_r == `CATH_HDR_P3)
        p3_r <= lnk.t2c_dat;
      if (st_r == ST_WAIT_HDR && rsp_vld)
        case_r <= rsp_case;
    end
  end

  // Outgoing byte, held until the terminal takes it
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      c2t_vld_r <= 1'b0;
      c2t_dat_r <= 8'h00;
      c2t_last_r <= 1'b0;
      c2t_more_r <= 1'b0;
    end
    else if (tx_ld)
    begin
      c2t_vld_r <= 1'b1;
      c2t_dat_r <= tx_byte;
      c2t_last_r <= lnk.t1_mode && seg_last; // R21
      c2t_more_r <= lnk.t1_mode && seg_more; // R21
    end
    else if (lnk.c2t_rdy)
      c2t_vld_r <= 1'b0;
  end

  // Ready only while a byte is expected; header reception is off in block mode
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      rdy_r <= 1'b0;
    else
      rdy_r <= (st_nxt == ST_RX_HDR && !lnk.t1_mode) || st_nxt == ST_RX_DAT ||
        st_nxt == ST_RX_T1;
  end

  // User side strobes
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cmd_byte_r <= 8'h00;
      cmd_vld_r <= 1'b0;
      cmd_end_r <= 1'b0;
      dat_adv_r <= 1'b0;
    end
    else
    begin
      cmd_byte_r <= lnk.t2c_dat;
      cmd_vld_r <= rx_take; // R19
      cmd_end_r <= fin;
      dat_adv_r <= adv;
    end
  end

  assign lnk.t2c_rdy = rdy_r;
  assign lnk.c2t_dat = c2t_dat_r;
  assign lnk.c2t_vld = c2t_vld_r;
  assign lnk.c2t_last = c2t_last_r;
  assign lnk.c2t_more = c2t_more_r;
  assign cmd_byte = cmd_byte_r;
  assign cmd_vld = cmd_vld_r;
  assign cmd_end = cmd_end_r;
  assign dat_adv = dat_adv_r;
endmodule

// ---- src/cath_term.sv ----
// Terminal end of the APDU transport: header build, data under procedure bytes, retrieval
`timescale 1ns/1ns
`include "cath_defs.svh"
module cath_term
  import cath_pkg::*;
#(
  parameter int IFSC = 32
)
(
  input logic core_clk,
  input logic rst_n,
  cath_link_if.term lnk,
  input logic t1_sel,
  input logic req_vld,
  input cath_case_t req_case,
  input logic [31:0] req_hdr,
  input logic [7:0] req_lc,
  input logic [8:0] req_le,
  input logic [7:0] req_dat,
  output logic dat_adv,
  output logic busy,
  output logic [7:0] rsp_byte,
  output logic rsp_vld,
  output logic [15:0] rsp_sw,
  output logic done
);
  typedef enum logic [2:0] {ST_IDLE, ST_TX_HDR, ST_PB, ST_SW2, ST_TX_DAT, ST_RX_DAT,
    ST_T1_LE, ST_RX_T1} cath_term_st_t;

  cath_term_st_t st_r;
  cath_term_st_t st_nxt;
  cath_case_t case_r;
  logic [8:0] idx_r;
  logic [8:0] idx_nxt;
  logic [31:0] hdr_r;
  logic [7:0] p3_r;
  logic [7:0] dcnt_r;
  logic [8:0] le_r;
  logic [7:0] sw1_r;
  logic [7:0] sh1_r;
  logic [7:0] sh2_r;
  logic [1:0] n_r;
  logic one_r;
  logic one_nxt;
  logic c4_sent_r;
  logic t1_r;
  logic [7:0] t2c_dat_r;
  logic t2c_vld_r;
  logic t2c_last_r;
  logic t2c_more_r;
  logic rdy_r;
  logic dat_adv_r;
  logic busy_r;
  logic [7:0] rsp_byte_r;
  logic rsp_vld_r;
  logic [15:0] rsp_sw_r;
  logic done_r;
  logic tx_ld;
  logic [7:0] tx_byte;
  logic last_b;
  logic adv;
  logic emit;
  logic fin;
  logic resend;
  logic gr;
  logic rx_take;
  logic tx_free;
  logic seg_last;
  logic seg_more;
  logic [7:0] ins;

  assign rx_take = lnk.c2t_vld && rdy_r;
  assign tx_free = !t2c_vld_r || lnk.t2c_rdy;
  assign ins = hdr_r[23:16];

  // Chaining of outgoing block protocol commands
  cath_blk_seg #(
    .IFS(IFSC)
  ) u_seg (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .beat(tx_ld && t1_r),
    .msg_last(last_b),
    .blk_last(seg_last),
    .blk_more(seg_more)
  );

  // Exchange sequencing
  always_comb
  begin
    st_nxt = st_r;
    idx_nxt = idx_r;
    one_nxt = one_r;
    tx_ld = 1'b0;
    tx_byte = 8'h00;
    last_b = 1'b0;
    adv = 1'b0;
    emit = 1'b0;
    fin = 1'b0;
    resend = 1'b0;
    gr = 1'b0;
    unique case (st_r)
      ST_IDLE:
      begin
        idx_nxt = 9'h000;
        if (req_vld)
          st_nxt = ST_TX_HDR;
      end
      ST_TX_HDR:
      begin
        if (tx_free)
        begin
          tx_ld = 1'b1;
          idx_nxt = idx_r + 9'h001;
          unique case (idx_r[1:0])
            2'h0: tx_byte = (idx_r == `CATH_HDR_P3) ? p3_r : hdr_r[31:24];
            2'h1: tx_byte = hdr_r[23:16];
            2'h2: tx_byte = hdr_r[15:8];
            2'h3: tx_byte = hdr_r[7:0];
          endcase
          if (!t1_r && idx_r == `CATH_HDR_P3)
            st_nxt = ST_PB;
          else if (t1_r && (idx_r == `CATH_HDR_P3 ||
                   (case_r == CASE_1 && idx_r == `CATH_T1_HDR_LAST)))
          begin
            last_b = case_r == CASE_1 || case_r == CASE_2; // R19
            st_nxt = last_b ? ST_RX_T1 : ST_TX_DAT;
          end
        end
      end
      ST_PB:
      begin
        if (rx_take && lnk.c2t_dat != `CATH_PB_NULL)
        begin
          if (lnk.c2t_dat == ins && dcnt_r != 8'h00)
            st_nxt = ST_TX_DAT; // R05
          else if (lnk.c2t_dat == ~ins && dcnt_r != 8'h00)
          begin
            one_nxt = 1'b1;
            st_nxt = ST_TX_DAT;
          end
          else if (lnk.c2t_dat == ins)
          begin
            idx_nxt = cath_le(p3_r);
            st_nxt = ST_RX_DAT;
          end
          else
            st_nxt = ST_SW2; // R05
        end
      end
      ST_TX_DAT:
      begin
        // One idle cycle between data bytes lets the user step its data
        if (!t2c_vld_r)
        begin
          tx_ld = 1'b1;
          tx_byte = req_dat;
          adv = 1'b1;
          one_nxt = 1'b0;
          last_b = t1_r && dcnt_r == 8'h01 && case_r == CASE_3; // R22
          if (t1_r && dcnt_r == 8'h01)
            st_nxt = (case_r == CASE_4) ? ST_T1_LE : ST_RX_T1;
          else if (!t1_r && (dcnt_r == 8'h01 || one_r))
            st_nxt = ST_PB; // R05
        end
      end
      ST_T1_LE:
      begin
        if (tx_free)
        begin
          tx_ld = 1'b1;
          tx_byte = le_r[7:0];
          last_b = 1'b1; // R19 R22
          st_nxt = ST_RX_T1;
        end
      end
      ST_RX_DAT:
      begin
        if (rx_take)
        begin
          emit = 1'b1; // R03
          idx_nxt = idx_r - 9'h001;
          if (idx_r == 9'h001)
            st_nxt = ST_PB;
        end
      end
      ST_SW2:
      begin
        if (rx_take)
        begin
          idx_nxt = 9'h000;
          if (sw1_r == `CATH_SW1_LEN && case_r == CASE_2)
            resend = 1'b1; // R13
          else if (sw1_r == `CATH_SW1_GET)
            gr = 1'b1; // R09 R11
          else if (c4_sent_r && cath_sw_warn({sw1_r, lnk.c2t_dat}))
            gr = 1'b1; // R10 R11
          else
            fin = 1'b1; // R03 R23
          st_nxt = fin ? ST_IDLE : ST_TX_HDR;
        end
      end
      ST_RX_T1:
      begin
        if (rx_take)
        begin
          emit = n_r == 2'h2; // R21
          if (!lnk.c2t_more && lnk.c2t_last)
          begin
            fin = 1'b1; // R19 R21
            st_nxt = ST_IDLE;
          end
        end
      end
    endcase
  end

  // State and command context
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st_r <= ST_IDLE;
      idx_r <= 9'h000;
      one_r <= 1'b0;
      case_r <= CASE_1;
      hdr_r <= 32'h0000_0000;
      p3_r <= 8'h00;
      dcnt_r <= 8'h00;
      le_r <= 9'h000;
      c4_sent_r <= 1'b0;
      t1_r <= 1'b0;
      sw1_r <= 8'h00;
    end
    else
    begin
      st_r <= st_nxt;
      idx_r <= idx_nxt;
      one_r <= one_nxt;
      if (st_r == ST_IDLE && req_vld)
      begin
        case_r <= req_case;
        hdr_r <= req_hdr;
        le_r <= req_le;
        t1_r <= t1_sel;
        c4_sent_r <= 1'b0;
        dcnt_r <= (req_case == CASE_3 || req_case == CASE_4) ? req_lc : 8'h00; // R04
        if (req_case == CASE_1)
          p3_r <= 8'h00; // R01
        else if (req_case == CASE_2)
          p3_r <= req_le[7:0];
        else
          p3_r <= req_lc; // R07
      end
      if (adv)
        dcnt_r <= dcnt_r - 8'h01;
      if (adv && dcnt_r == 8'h01 && case_r == CASE_4 && !t1_r)
        c4_sent_r <= 1'b1;
      if (st_r == ST_PB && rx_take)
        sw1_r <= lnk.c2t_dat;
      if (resend)
        p3_r <= lnk.c2t_dat; // R13
      if (gr)
      begin
        hdr_r[23:0] <= {`CATH_INS_GET_RSP, 16'h0000}; // R09
        p3_r <= (sw1_r == `CATH_SW1_GET) ? lnk.c2t_dat : 8'h00; // R09 R10
        case_r <= CASE_2; // R11
        c4_sent_r <= 1'b0;
      end
    end
  end

  // Two-byte delay separates the trailing status from block response data
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || st_r == ST_IDLE)
    begin
      sh1_r <= 8'h00;
      sh2_r <= 8'h00;
      n_r <= 2'h0;
    end
    else if (st_r == ST_RX_T1 && rx_take)
    begin
      sh1_r <= sh2_r;
      sh2_r <= lnk.c2t_dat;
      n_r <= (n_r == 2'h2) ? n_r : n_r + 2'h1;
    end
  end

  // Outgoing byte, held until the card takes it
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      t2c_vld_r <= 1'b0;
      t2c_dat_r <= 8'h00;
      t2c_last_r <= 1'b0;
      t2c_more_r <= 1'b0;
    end
    else if (tx_ld)
    begin
      t2c_vld_r <= 1'b1;
      t2c_dat_r <= tx_byte;
      t2c_last_r <= t1_r && seg_last; // R22
      t2c_more_r <= t1_r && seg_more; // R22
    end
    else if (lnk.t2c_rdy)
      t2c_vld_r <= 1'b0;
  end

  // Link ready and user side outputs
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      rdy_r <= 1'b0;
      dat_adv_r <= 1'b0;
      busy_r <= 1'b0;
      rsp_byte_r <= 8'h00;
      rsp_vld_r <= 1'b0;
      rsp_sw_r <= 16'h0000;
      done_r <= 1'b0;
    end
    else
    begin
      rdy_r <= st_nxt == ST_PB || st_nxt == ST_SW2 || st_nxt == ST_RX_DAT ||
        st_nxt == ST_RX_T1;
      dat_adv_r <= adv;
      busy_r <= st_nxt != ST_IDLE;
      rsp_vld_r <= emit;
      rsp_byte_r <= t1_r ? sh1_r : lnk.c2t_dat;
      done_r <= fin;
      if (fin)
        rsp_sw_r <= {t1_r ? sh2_r : sw1_r, lnk.c2t_dat}; // R03
    end
  end

  assign lnk.t1_mode = t1_r;
  assign lnk.t2c_dat = t2c_dat_r;
  assign lnk.t2c_vld = t2c_vld_r;
  assign lnk.t2c_last = t2c_last_r;
  assign lnk.t2c_more = t2c_more_r;
  assign lnk.c2t_rdy = rdy_r;
  assign dat_adv = dat_adv_r;
  assign busy = busy_r;
  assign rsp_byte = rsp_byte_r;
  assign rsp_vld = rsp_vld_r;
  assign rsp_sw = rsp_sw_r;
  assign done = done_r;
endmodule

// ---- tb/cath_link_assertions.sv ----
// Protocol checks on the byte link between the card and terminal ends
`timescale 1ns/1ns
module cath_link_assertions #(
  parameter int IFSC = 32,
  parameter int IFSD = 32
)
(
  input logic core_clk,
  input logic rst_n,
  input logic t1_mode,
  input logic [7:0] t2c_dat,
  input logic t2c_vld,
  input logic t2c_last,
  input logic t2c_more,
  input logic t2c_rdy,
  input logic [7:0] c2t_dat,
  input logic c2t_vld,
  input logic c2t_last,
  input logic c2t_more,
  input logic c2t_rdy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [8:0] tcnt_r;
  logic [8:0] ccnt_r;
  sequence t2c_take;
    t2c_vld && t2c_rdy;
  endsequence
  sequence c2t_take;
    c2t_vld && c2t_rdy;
  endsequence
  // Bytes taken in the open block; cleared outside block mode so T=0 never wraps
  always_ff @(posedge core_clk)
    if (!rst_n || !t1_mode || (t2c_vld && t2c_rdy && t2c_last))
      tcnt_r <= 9'h000;
    else if (t2c_vld && t2c_rdy)
      tcnt_r <= tcnt_r + 9'h001;
  // Same count for the card-to-terminal direction
  always_ff @(posedge core_clk)
    if (!rst_n || !t1_mode || (c2t_vld && c2t_rdy && c2t_last))
      ccnt_r <= 9'h000;
    else if (c2t_vld && c2t_rdy)
      ccnt_r <= ccnt_r + 9'h001;
  a_t2c_holds: assert property (t2c_vld && !t2c_rdy |=> t2c_vld && $stable({t2c_dat, t2c_last}))
    else $error("terminal byte changed before taken");
  a_c2t_holds: assert property (c2t_vld && !c2t_rdy |=> c2t_vld && $stable({c2t_dat, c2t_last}))
    else $error("card byte changed before taken");
  a_t0_no_last: assert property (!t1_mode |-> !(t2c_vld && t2c_last) && !(c2t_vld && c2t_last))
    else $error("block end flag in character mode");
  a_t0_no_more: assert property (!t1_mode |-> !(t2c_vld && t2c_more) && !(c2t_vld && c2t_more))
    else $error("chain flag in character mode");
  a_cmd_blk_len: assert property (t2c_take |-> !t1_mode || tcnt_r != IFSC - 1 || t2c_last)
    else $error("command block longer than its limit");
  a_rsp_blk_len: assert property (c2t_take |-> !t1_mode || ccnt_r != IFSD - 1 || c2t_last)
    else $error("response block longer than its limit");
  a_mode_steady: assert property (t2c_vld || c2t_vld |-> $stable(t1_mode))
    else $error("protocol mode changed mid exchange");
  a_reset_quiet: assert property ($rose(rst_n) |-> !t2c_vld && !c2t_vld && !t2c_rdy && !c2t_rdy)
    else $error("link active straight after reset");
endmodule

// ---- tb/card_apdu_transport_handler_test.sv ----
// Bench joining terminal and card ends, with queued expectations
`timescale 1ns/1ns
module card_apdu_transport_handler_test
  import cath_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic t1_sel = 1'b0;
  logic req_vld = 1'b0;
  cath_case_t req_case = CASE_1;
  cath_case_t cc = CASE_1;
  cath_case_t c_case = CASE_1;
  logic [31:0] req_hdr = 32'h0000_0000;
  logic [7:0] req_lc = 8'h00;
  logic [8:0] req_le = 9'h000;
  logic [8:0] len0 = 9'h000;
  logic [7:0] cb = 8'h00;
  logic [7:0] rb = 8'h00;
  logic [1:0] okv = 2'h0;
  logic c_vld = 1'b0;
  logic c_ok = 1'b0;
  logic [15:0] c_sw = 16'h0000;
  logic [7:0] req_dat, c_dat, cmd_byte, rsp_byte;
  logic [8:0] c_len;
  logic t_adv, c_adv, busy, t_vld, done, cmd_vld, cmd_end;
  logic [15:0] t_sw;
  logic [7:0] qb[$];
  logic [7:0] qc[$];
  logic [15:0] qs[$];
  int k = 0;
  int j = 0;
  int na = 0;
  int err_count = 0;
  int n_checks = 0;
  integer seed = 32'h25be;
  // Test table: t1, case, lc, le, ok bits, status, available length
  logic [59:0] tv [15] = '{
    60'h000_0000_3900_0000,
    60'h010_0004_3900_0004,
    60'h010_0008_3900_0005,
    60'h010_0003_3900_0007,
    60'h010_0100_3900_0100,
    60'h010_0004_06A8_2004,
    60'h020_0000_3900_0000,
    60'h020_5000_06A8_2000,
    60'h030_6000_3900_0100,
    60'h030_3000_1628_3000,
    60'h030_3000_16A8_2000,
    60'h100_0000_3900_0000,
    60'h131_400A_3900_0014,
    60'h110_0005_36A8_2005,
    60'h120_9000_3628_3003};
  // Data sources step on each advance pulse
  assign req_dat = cb + j[7:0];
  assign c_dat = rb + k[7:0];
  assign c_len = len0 - k[8:0];
  always #10 core_clk = ~core_clk;
  cath_link_if lnk ();
  cath_term #(.IFSC(8)) cath_term_inst (.core_clk(core_clk), .rst_n(rst_n), .lnk(lnk.term),
    .t1_sel(t1_sel), .req_vld(req_vld), .req_case(req_case), .req_hdr(req_hdr),
    .req_lc(req_lc), .req_le(req_le), .req_dat(req_dat), .dat_adv(t_adv), .busy(busy),
    .rsp_byte(rsp_byte), .rsp_vld(t_vld), .rsp_sw(t_sw), .done(done));
  cath_card #(.IFSD(8)) cath_card_inst (.core_clk(core_clk), .rst_n(rst_n), .lnk(lnk.card),
    .cmd_byte(cmd_byte), .cmd_vld(cmd_vld), .cmd_end(cmd_end), .rsp_vld(c_vld),
    .rsp_case(c_case), .rsp_ok(c_ok), .rsp_sw(c_sw), .rsp_len(c_len), .rsp_dat(c_dat),
    .dat_adv(c_adv));
  cath_link_assertions #(.IFSC(8), .IFSD(8)) cath_link_assertions_inst (.core_clk(core_clk),
    .rst_n(rst_n), .t1_mode(lnk.t1_mode), .t2c_dat(lnk.t2c_dat), .t2c_vld(lnk.t2c_vld),
    .t2c_last(lnk.t2c_last), .t2c_more(lnk.t2c_more), .t2c_rdy(lnk.t2c_rdy),
    .c2t_dat(lnk.c2t_dat), .c2t_vld(lnk.c2t_vld), .c2t_last(lnk.c2t_last),
    .c2t_more(lnk.c2t_more), .c2t_rdy(lnk.c2t_rdy));

  task automatic chk_b(input logic [7:0] e, input logic [7:0] a);
    n_checks++;
    if (a !== e)
    begin
      err_count++;
      $display("[FAIL] t=%0t exp %h got %h", $time, e, a);
    end
  endtask

  task automatic chk_w(input logic [15:0] e, input logic [15:0] a);
    n_checks++;
    if (a !== e)
    begin
      err_count++;
      $display("[FAIL] t=%0t exp %h got %h", $time, e, a);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Card user: answer each finished header or data phase; a case 4 follow-up is case 2
  always @(negedge core_clk)
  begin
    c_vld <= cmd_end;
    if (c_adv)
      k++;
    if (t_adv)
      j++;
    if (cmd_end)
    begin
      c_case <= cc;
      c_ok <= (na != 0) ? okv[1] : okv[0];
      if (na == 1 && !t1_sel && cc == CASE_4)
        cc = CASE_2;
      na++;
    end
  end

  // Oldest note against each result; card side bytes only while notes remain
  always @(posedge core_clk)
  begin
    if (t_vld)
      chk_b(qb.size() ? qb.pop_front() : 8'hxx, rsp_byte);
    if (cmd_vld && qc.size() != 0)
      chk_b(qc.pop_front(), cmd_byte);
    if (done)
      chk_w(qs.size() ? qs.pop_front() : 16'hxxxx, t_sw);
  end

  task automatic run(input int i, input logic [59:0] v);
    logic [39:0] g;
    logic [8:0] n;
    int w;
    @(negedge core_clk);
    t1_sel = v[56];
    req_case = cath_case_t'(v[53:52]);
    req_lc = v[51:44];
    if (v[53] && req_lc == 8'h00)
      req_lc = 8'h01 + 8'({$random(seed)} % 255);
    req_le = v[40:32];
    okv = v[29:28];
    c_sw = v[27:12];
    len0 = v[8:0];
    req_hdr = $random(seed);
    req_hdr[23:16] = 8'hB0;
    cb = 8'($random(seed));
    rb = 8'($random(seed));
    k = 0;
    j = 0;
    na = 0;
    cc = req_case;
    g = {req_hdr, (req_case == CASE_2) ? req_le[7:0] : req_lc};
    for (w = 4; w >= (t1_sel ? 1 : 0); w--)
      qc.push_back(g[w*8+:8]);
    if (t1_sel && req_case >= CASE_3)
      qc.push_back(req_lc);
    for (w = 0; w < ((req_case >= CASE_3 && (t1_sel || okv[0])) ? req_lc : 0); w++)
      qc.push_back(cb + w[7:0]);
    if (t1_sel && req_case[0])
      qc.push_back(req_le[7:0]);
    g = {req_hdr[31:24], 24'hC0_0000, okv[1] ? len0[7:0] : 8'h00};
    if (!t1_sel && req_case == CASE_4 && okv[0] && (okv[1] || c_sw[15:9] == 7'h31))
      for (w = 4; w >= 0; w--)
        qc.push_back(g[w*8+:8]);
    n = (okv == 2'h3 && (!t1_sel || c_sw[15:12] == 4'h9 || c_sw[15:9] == 7'h31)) ? len0 : 0;
    for (w = 0; w < n; w++)
      qb.push_back(rb + w[7:0]);
    qs.push_back(c_sw);
    req_vld = 1'b1;
    @(negedge core_clk);
    req_vld = 1'b0;
    chk_b(8'h01, {7'h00, busy});
    for (w = 0; w < 5000 && done !== 1'b1; w++)
      @(negedge core_clk);
    // One more edge lets the watcher take the final notes first
    @(negedge core_clk);
    chk_b(8'h00, {7'h00, busy});
    $display("test %0d ended", i);
    if (w == 5000 || qb.size() != 0 || qc.size() != 0 || qs.size() != 0)
    begin
      err_count++;
      $display("[FAIL] t=%0t test %0d left %h %h", $time, i, qb.size(), qc.size());
      tally_and_finish();
    end
  endtask

  // Reset for 16 cycles, then the table in order
  initial
  begin
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    foreach (tv[i])
      run(i, tv[i]);
    tally_and_finish();
  end
endmodule
